// ===== design/mpf_pkg.sv
package mpf_pkg;

    // serial bus addresses
    localparam logic [6:0] SMB_DEV_ADDR     = 7'h5C;
    localparam logic [6:0] SMB_DEFAULT_ADDR = 7'h61;

    // register offsets
    localparam logic [7:0] CFG1_OFF = 8'h10;
    localparam logic [7:0] CFG2_OFF = 8'h11;
    localparam logic [7:0] CFG3_OFF = 8'h12;
    localparam logic [7:0] CFG4_OFF = 8'h13;

    // values after reset
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] CFG3_RST = 8'h00;
    localparam logic [7:0] CFG4_RST = 8'h00;

    // bit positions
    localparam int CFG1_VID_BIT  = 7;
    localparam int CFG1_D1_BIT   = 6;
    localparam int CFG1_D3_BIT   = 5;
    localparam int CFG1_FS5_BIT  = 0;
    localparam int CFG2_FS6_BIT  = 7;
    localparam int CFG2_FD4_BIT  = 6;
    localparam int CFG2_FS7_BIT  = 3;
    localparam int CFG2_FS8_BIT  = 2;
    localparam int CFG3_FFF_BIT  = 1;
    localparam int CFG4_FD1_BIT  = 3;
    localparam int CFG4_FD2_BIT  = 2;
    localparam int CFG4_OT1_BIT  = 7;
    localparam int CFG4_OT2_BIT  = 5;

    // plain voltage monitor enable positions
    localparam int VM_12V1     = 0;
    localparam int VM_12V2     = 1;
    localparam int VM_3V3      = 2;
    localparam int VM_2V5_P15  = 3;
    localparam int VM_0V9      = 4;
    localparam int VM_5V       = 5;
    localparam int VM_12V3     = 6;
    localparam int VM_1V8      = 7;
    localparam int VM_2V5_P24  = 8;
    localparam int VM_1V2      = 9;
    localparam int VM_1V5_P28  = 10;
    localparam int VM_1V5_P29  = 11;
    localparam int VM_COUNT    = 12;

    localparam logic [3:0] BIT_COUNT = 4'h8;

    typedef enum logic [3:0] {
        MPF_IDLE = 4'b0000,
        MPF_ADDR = 4'b0001,
        MPF_AACK = 4'b0011,
        MPF_CMD  = 4'b0010,
        MPF_CACK = 4'b0110,
        MPF_DATA = 4'b0111,
        MPF_DACK = 4'b0101,
        MPF_READ = 4'b0100,
        MPF_RACK = 4'b1100
    } mpf_state_e;

endpackage : mpf_pkg

// ===== design/mpf_sync3.sv
`timescale 1ns/1ps
module mpf_sync3 (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic reset_i,
    // raw pin and filtered level
    input  wire logic raw_i,
    output logic      level_o
);
    logic s1_q, s2_q, s3_q, lvl_q;
    logic lvl_d;

    always_comb begin
        // a change counts only once stages two and three agree
        lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            s3_q  <= 1'b1;
            lvl_q <= 1'b1;
        end else begin
            s1_q  <= raw_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_o = lvl_q;
endmodule : mpf_sync3

// ===== design/mpf_pin_select.sv
`timescale 1ns/1ps
module mpf_pin_select
    import mpf_pkg::*;
(
    // clock and reset
    input  wire logic                mclk_i,
    input  wire logic                reset_i,
    // management serial bus
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe_o,
    // pin function enables
    output logic                     processor_id_en_o,
    output logic [7:0]               fan_speed_input_en_o,
    output logic [3:0]               fan_drive_output_en_o,
    output logic [1:0]               remote_diode_pair_en_o,
    output logic [1:0]               termination_monitor_en_o,
    output logic [1:0]               core_voltage_monitor_en_o,
    output logic [1:0]               regulator_hot_input_en_o,
    output logic [1:0]               overtemp_io_en_o,
    output logic                     battery_monitor_en_o,
    output logic                     force_full_fan_en_o,
    output logic [VM_COUNT-1:0]      volt_monitor_en_o
);
    logic       scl_f, sda_f, scl_p_q, sda_p_q;
    logic       scl_rise, scl_fall, bus_start, bus_stop;
    mpf_state_e state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rd_q, rd_d, rd_mux;
    logic       oe_q, oe_d, mack_q, mack_d, wr_fire;
    logic       live_q;
    logic [7:0] cfg1_q, cfg2_q, cfg3_q, cfg4_q;
    logic [7:0] cfg1_d, cfg2_d, cfg3_d, cfg4_d;
    logic       vid_d, bat_d, fff_d;
    logic [7:0] fs_d;
    logic [3:0] fd_d;
    logic [1:0] dp_d, tm_d, cv_d, rh_d, ot_d;
    logic [VM_COUNT-1:0] vm_d;

    mpf_sync3 u_scl_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .raw_i   (scl_i),
        .level_o (scl_f)
    );

    mpf_sync3 u_sda_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .raw_i   (sda_i),
        .level_o (sda_f)
    );

    assign scl_rise  = scl_f & ~scl_p_q;
    assign scl_fall  = ~scl_f & scl_p_q;
    assign bus_start = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign bus_stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;

    always_comb begin
        case (ptr_q)
            CFG1_OFF: rd_mux = cfg1_q;
            CFG2_OFF: rd_mux = cfg2_q;
            CFG3_OFF: rd_mux = cfg3_q;
            CFG4_OFF: rd_mux = cfg4_q;
            default:  rd_mux = 8'h00;
        endcase
    end

    // serial bus slave: pointer byte first, then data bytes to that pointer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        ptr_d   = ptr_q;
        rd_d    = rd_q;
        oe_d    = oe_q;
        mack_d  = mack_q;
        wr_fire = 1'b0;
        if (bus_start) begin
            state_d = MPF_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
        end else if (bus_stop) begin
            state_d = MPF_IDLE;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                MPF_ADDR, MPF_CMD, MPF_DATA: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_f};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BIT_COUNT) begin
                        cnt_d = 4'h0;
                        oe_d  = 1'b1;
                        if (state_q == MPF_ADDR) begin
                            if (sh_q[7:1] == SMB_DEV_ADDR || sh_q[7:1] == SMB_DEFAULT_ADDR) begin
                                state_d = MPF_AACK;
                                rd_d    = rd_mux;
                            end else begin
                                // not ours: stay quiet until the next start
                                state_d = MPF_IDLE;
                                oe_d    = 1'b0;
                            end
                        end else if (state_q == MPF_CMD) begin
                            state_d = MPF_CACK;
                            ptr_d   = sh_q;
                        end else begin
                            state_d = MPF_DACK;
                            wr_fire = 1'b1;
                        end
                    end
                end
                MPF_AACK: begin
                    if (scl_fall) begin
                        if (sh_q[0]) begin
                            state_d = MPF_READ;
                            oe_d    = ~rd_q[7];
                        end else begin
                            state_d = MPF_CMD;
                            oe_d    = 1'b0;
                        end
                    end
                end
                MPF_CACK, MPF_DACK: begin
                    if (scl_fall) begin
                        state_d = MPF_DATA;
                        oe_d    = 1'b0;
                    end
                end
                MPF_READ: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == BIT_COUNT) begin
                            state_d = MPF_RACK;
                            oe_d    = 1'b0;
                        end else begin
                            oe_d = ~rd_q[3'(4'h7 - cnt_q)];
                        end
                    end
                end
                MPF_RACK: begin
                    if (scl_rise) begin
                        mack_d = ~sda_f;
                    end else if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (mack_q) begin
                            state_d = MPF_READ;
                            rd_d    = rd_mux;
                            oe_d    = ~rd_mux[7];
                        end else begin
                            state_d = MPF_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    // register file; every bit is stored as written
    always_comb begin
        cfg1_d = cfg1_q;
        cfg2_d = cfg2_q;
        cfg3_d = cfg3_q;
        cfg4_d = cfg4_q;
        if (wr_fire) begin
            case (ptr_q)
                CFG1_OFF: cfg1_d = sh_q;
                CFG2_OFF: cfg2_d = sh_q;
                CFG3_OFF: cfg3_d = sh_q;
                CFG4_OFF: cfg4_d = sh_q;
                default:  cfg1_d = cfg1_q;
            endcase
        end
    end

    // pin function decode
    always_comb begin
        vid_d = cfg1_q[CFG1_VID_BIT];
        fs_d  = {cfg2_q[CFG2_FS8_BIT], cfg2_q[CFG2_FS7_BIT], cfg2_q[CFG2_FS6_BIT], cfg1_q[CFG1_FS5_BIT],
                 cfg1_q[1], cfg1_q[2], cfg1_q[3], cfg1_q[4]};
        fs_d[3:0] = vid_d ? 4'h0 : fs_d[3:0];
        fd_d  = {cfg2_q[CFG2_FD4_BIT], 1'b0, cfg4_q[CFG4_FD2_BIT], cfg4_q[CFG4_FD1_BIT]};
        fd_d[1:0] = vid_d ? 2'b00 : fd_d[1:0];
        dp_d  = {cfg1_q[CFG1_D3_BIT], cfg1_q[CFG1_D1_BIT]};
        tm_d  = ~dp_d;
        cv_d  = {cfg3_q[7:6] == 2'b00, cfg2_q[1:0] == 2'b00};
        rh_d  = {cfg3_q[3], cfg3_q[5]};
        bat_d = (cfg3_q[3:2] == 2'b00);
        fff_d = ~cfg3_q[CFG3_FFF_BIT];
        // pin 28 also yields to the processor ID function
        ot_d  = {cfg4_q[CFG4_OT2_BIT], cfg4_q[CFG4_OT1_BIT] & ~vid_d};
        vm_d  = '0;
        vm_d[VM_12V1]    = ~cfg1_q[CFG1_FS5_BIT];
        vm_d[VM_12V2]    = ~cfg2_q[CFG2_FS6_BIT];
        vm_d[VM_3V3]     = ~cfg2_q[CFG2_FD4_BIT];
        vm_d[VM_2V5_P15] = ~cfg1_q[CFG1_D1_BIT];
        vm_d[VM_0V9]     = ~cfg1_q[CFG1_D3_BIT];
        vm_d[VM_5V]      = ~cfg2_q[CFG2_FS7_BIT];
        vm_d[VM_12V3]    = ~cfg2_q[CFG2_FS8_BIT];
        vm_d[VM_1V8]     = (cfg2_q[1:0] == 2'b10);
        vm_d[VM_2V5_P24] = (cfg3_q[7:6] == 2'b01);
        vm_d[VM_1V2]     = (cfg3_q[5:4] == 2'b01);
        // no check of the 28/29 pairing: software must set both alike
        vm_d[VM_1V5_P28] = (cfg4_q[7:6] == 2'b01) & ~vid_d;
        vm_d[VM_1V5_P29] = (cfg4_q[5:4] == 2'b01);
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= MPF_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            ptr_q   <= 8'h00;
            rd_q    <= 8'h00;
            oe_q    <= 1'b0;
            mack_q  <= 1'b0;
            live_q  <= 1'b0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            cfg1_q  <= CFG1_RST;
            cfg2_q  <= CFG2_RST;
            cfg3_q  <= CFG3_RST;
            cfg4_q  <= CFG4_RST;
            processor_id_en_o         <= 1'b0;
            fan_speed_input_en_o      <= 8'h00;
            fan_drive_output_en_o     <= 4'h0;
            remote_diode_pair_en_o    <= 2'b00;
            termination_monitor_en_o  <= 2'b00;
            core_voltage_monitor_en_o <= 2'b00;
            regulator_hot_input_en_o  <= 2'b00;
            overtemp_io_en_o          <= 2'b00;
            battery_monitor_en_o      <= 1'b0;
            force_full_fan_en_o       <= 1'b0;
            volt_monitor_en_o         <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            ptr_q   <= ptr_d;
            rd_q    <= rd_d;
            oe_q    <= oe_d;
            mack_q  <= mack_d;
            live_q  <= 1'b1;
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
            cfg1_q  <= cfg1_d;
            cfg2_q  <= cfg2_d;
            cfg3_q  <= cfg3_d;
            cfg4_q  <= cfg4_d;
            processor_id_en_o         <= vid_d;
            fan_speed_input_en_o      <= fs_d;
            fan_drive_output_en_o     <= fd_d;
            remote_diode_pair_en_o    <= dp_d;
            termination_monitor_en_o  <= tm_d;
            core_voltage_monitor_en_o <= cv_d;
            regulator_hot_input_en_o  <= rh_d;
            overtemp_io_en_o          <= ot_d;
            battery_monitor_en_o      <= bat_d;
            force_full_fan_en_o       <= fff_d;
            volt_monitor_en_o         <= vm_d;
        end
    end

    // open drain: only ever pulls low
    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_q;

    default clocking cb @(posedge mclk_i); endclocking
    // hold checks off for the first edge after release, while outputs still show the reset value
    default disable iff (reset_i || !live_q);

    property p_vid;
        cfg1_q[7] |=> processor_id_en_o && fan_speed_input_en_o[3:0] == 4'h0 && !overtemp_io_en_o[0]
                      && fan_drive_output_en_o[1:0] == 2'b00 && !volt_monitor_en_o[VM_1V5_P28];
    endproperty
    a_vid: assert property (p_vid) else $error("processor id override missing");
    property p_fs14;
        !cfg1_q[7] |=> fan_speed_input_en_o[0] == $past(cfg1_q[4]) && fan_speed_input_en_o[3] == $past(cfg1_q[1]);
    endproperty
    a_fs14: assert property (p_fs14) else $error("fan speed 1-4 select wrong");
    property p_fs5;
        ##1 fan_speed_input_en_o[4] == $past(cfg1_q[0]) && volt_monitor_en_o[VM_12V1] == !$past(cfg1_q[0]);
    endproperty
    a_fs5: assert property (p_fs5) else $error("pin 7 select wrong");
    property p_fs6;
        $rose(cfg2_q[7]) |=> fan_speed_input_en_o[5] && !volt_monitor_en_o[VM_12V2];
    endproperty
    a_fs6: assert property (p_fs6) else $error("pin 8 select wrong");
    property p_fd4;
        ##1 fan_drive_output_en_o[3] != volt_monitor_en_o[VM_3V3];
    endproperty
    a_fd4: assert property (p_fd4) else $error("pin 13 select wrong");
    property p_d1;
        !cfg1_q[6] |=> !remote_diode_pair_en_o[0] && termination_monitor_en_o[0] && volt_monitor_en_o[VM_2V5_P15];
    endproperty
    a_d1: assert property (p_d1) else $error("pins 15/16 select wrong");
    property p_d3;
        cfg1_q[5] |=> remote_diode_pair_en_o[1] && !termination_monitor_en_o[1] && !volt_monitor_en_o[VM_0V9];
    endproperty
    a_d3: assert property (p_d3) else $error("pins 19/20 select wrong");
    property p_fs78;
        cfg2_q[3:2] == 2'b00 |=> volt_monitor_en_o[VM_5V] && volt_monitor_en_o[VM_12V3]
                                 && fan_speed_input_en_o[7:6] == 2'b00;
    endproperty
    a_fs78: assert property (p_fs78) else $error("pins 21/22 select wrong");
    property p_p23;
        cfg2_q[1:0] == 2'b10 |=> volt_monitor_en_o[VM_1V8] && !core_voltage_monitor_en_o[0];
    endproperty
    a_p23: assert property (p_p23) else $error("pin 23 select wrong");
    property p_p24;
        cfg3_q[7:6] == 2'b00 |=> core_voltage_monitor_en_o[1] && !volt_monitor_en_o[VM_2V5_P24];
    endproperty
    a_p24: assert property (p_p24) else $error("pin 24 select wrong");
    property p_p25;
        cfg3_q[5] |=> regulator_hot_input_en_o[0] && !volt_monitor_en_o[VM_1V2];
    endproperty
    a_p25: assert property (p_p25) else $error("pin 25 select wrong");
    property p_p26;
        cfg3_q[3] |=> regulator_hot_input_en_o[1] && !battery_monitor_en_o;
    endproperty
    a_p26: assert property (p_p26) else $error("pin 26 select wrong");
    property p_p27;
        ##1 force_full_fan_en_o == !$past(cfg3_q[1]);
    endproperty
    a_p27: assert property (p_p27) else $error("pin 27 select wrong");
    property p_fd12;
        !cfg1_q[7] && cfg4_q[3:2] == 2'b11 |=> fan_drive_output_en_o[1:0] == 2'b11;
    endproperty
    a_fd12: assert property (p_fd12) else $error("pins 31/32 select wrong");
    property p_wr;
        wr_fire && ptr_q == CFG1_OFF |=> cfg1_q == $past(sh_q) ##1 processor_id_en_o == cfg1_q[7];
    endproperty
    a_wr: assert property (p_wr) else $error("register write not applied");
    property p_rd;
        state_q == MPF_AACK && scl_fall && sh_q[0] |=> state_q == MPF_READ && oe_q == !rd_q[7];
    endproperty
    a_rd: assert property (p_rd) else $error("read data first bit wrong");

    c_write: cover property (wr_fire && ptr_q == CFG4_OFF);
    c_read:  cover property (state_q == MPF_RACK ##[1:40] state_q == MPF_IDLE);
    c_vid:   cover property ($rose(processor_id_en_o));
endmodule : mpf_pin_select

// ===== sim/monitor_pin_function_select_test.sv
`timescale 1ns/1ps
module monitor_pin_function_select_test;
    import mpf_pkg::*;

    // clock, reset and bus lines
    logic                mclk_i;
    logic                reset_i;
    logic                scl_i;
    logic                m_sda;
    logic                sda_i;
    logic                sda_o;
    logic                sda_oe_o;
    // pin function enables
    logic                processor_id_en_o;
    logic [7:0]          fan_speed_input_en_o;
    logic [3:0]          fan_drive_output_en_o;
    logic [1:0]          remote_diode_pair_en_o;
    logic [1:0]          termination_monitor_en_o;
    logic [1:0]          core_voltage_monitor_en_o;
    logic [1:0]          regulator_hot_input_en_o;
    logic [1:0]          overtemp_io_en_o;
    logic                battery_monitor_en_o;
    logic                force_full_fan_en_o;
    logic [VM_COUNT-1:0] volt_monitor_en_o;
    logic [36:0]         pins;
    int                  mismatches;
    int                  n_checks;

    // open-drain data line: either party may pull it low
    assign sda_i = m_sda & (sda_oe_o ? sda_o : 1'b1);
    assign pins  = {processor_id_en_o, fan_speed_input_en_o, fan_drive_output_en_o, remote_diode_pair_en_o,
                    termination_monitor_en_o, core_voltage_monitor_en_o, regulator_hot_input_en_o,
                    overtemp_io_en_o, battery_monitor_en_o, force_full_fan_en_o, volt_monitor_en_o};

    mpf_pin_select u_dut (
        .mclk_i                    (mclk_i),
        .reset_i                   (reset_i),
        .scl_i                     (scl_i),
        .sda_i                     (sda_i),
        .sda_o                     (sda_o),
        .sda_oe_o                  (sda_oe_o),
        .processor_id_en_o         (processor_id_en_o),
        .fan_speed_input_en_o      (fan_speed_input_en_o),
        .fan_drive_output_en_o     (fan_drive_output_en_o),
        .remote_diode_pair_en_o    (remote_diode_pair_en_o),
        .termination_monitor_en_o  (termination_monitor_en_o),
        .core_voltage_monitor_en_o (core_voltage_monitor_en_o),
        .regulator_hot_input_en_o  (regulator_hot_input_en_o),
        .overtemp_io_en_o          (overtemp_io_en_o),
        .battery_monitor_en_o      (battery_monitor_en_o),
        .force_full_fan_en_o       (force_full_fan_en_o),
        .volt_monitor_en_o         (volt_monitor_en_o)
    );

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic test_done;
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // phases of 10 cycles keep well clear of the 2-cycle minimum after the input filter
    task automatic bit_io(input logic v, output logic r);
        m_sda <= v;
        tick(8);
        scl_i <= 1'b1;
        tick(5);
        r = sda_i;
        tick(5);
        scl_i <= 1'b0;
        tick(2);
    endtask : bit_io

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'b1, a);
        ack = ~a;
    endtask : xfer

    task automatic start_c;
        m_sda <= 1'b1;
        tick(8);
        scl_i <= 1'b1;
        tick(10);
        m_sda <= 1'b0;
        tick(10);
        scl_i <= 1'b0;
        tick(2);
    endtask : start_c

    task automatic stop_c;
        m_sda <= 1'b0;
        tick(8);
        scl_i <= 1'b1;
        tick(10);
        m_sda <= 1'b1;
        tick(10);
    endtask : stop_c

    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data, input logic exp_ack);
        logic [7:0] rx;
        logic       a;
        start_c();
        xfer({dev, 1'b0}, rx, a);
        check(64'(a), 64'(exp_ack), "address ack");
        if (a) begin
            xfer(ptr, rx, a);
            check(64'(a), 64'h1, "pointer ack");
            xfer(data, rx, a);
            check(64'(a), 64'h1, "data ack");
        end
        stop_c();
    endtask : wr

    // pointer set, then repeated start and a single byte read ended by no-ack
    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] rx;
        logic       a;
        start_c();
        xfer({SMB_DEV_ADDR, 1'b0}, rx, a);
        xfer(ptr, rx, a);
        start_c();
        xfer({SMB_DEV_ADDR, 1'b1}, rx, a);
        xfer(8'hFF, rx, a);
        stop_c();
        check(64'(rx), 64'(exp), "read back");
    endtask : rd

    task automatic cfg(input logic [31:0] v);
        for (int k = 0; k < 4; k++) begin
            wr(SMB_DEV_ADDR, 8'(CFG1_OFF + k), v[31-8*k -: 8], 1'b1);
        end
        for (int k = 0; k < 4; k++) begin
            rd(8'(CFG1_OFF + k), v[31-8*k -: 8]);
        end
        tick(4);
    endtask : cfg

    task automatic do_reset;
        reset_i <= 1'b1;
        tick(8);
        reset_i <= 1'b0;
        tick(6);
        check(64'(pins), 64'({1'h0, 8'h00, 4'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 1'h1, 1'h1, 12'h07F}),
              "pins after reset");
    endtask : do_reset

    initial begin
        tick(40000);
        mismatches++;
        test_done();
    end

    initial begin
        reset_i    = 1'b1;
        scl_i      = 1'b1;
        m_sda      = 1'b1;
        mismatches = 0;
        n_checks   = 0;
        do_reset();
        for (int k = 0; k < 4; k++) begin
            rd(8'(CFG1_OFF + k), 8'h00);
        end
        // diode pair one, six fan inputs, both pins thermal
        cfg(32'h5FC0_60AC);
        check(64'(pins), 64'({1'h0, 8'h3F, 4'hB, 2'h1, 2'h2, 2'h1, 2'h1, 2'h3, 1'h1, 1'h1, 12'h170}),
              "first preset");
        // processor ID overrides shared fan pins and thermal pin 28
        wr(SMB_DEV_ADDR, CFG1_OFF, 8'hDF, 1'b1);
        check(64'(pins), 64'({1'h1, 8'h30, 4'h8, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 1'h1, 1'h1, 12'h170}),
              "processor id");
        wr(SMB_DEV_ADDR, CFG3_OFF, 8'h62, 1'b1);
        check(64'(force_full_fan_en_o), 64'h0, "force full fan off");
        // foreign address must be ignored
        wr(7'h50, CFG1_OFF, 8'h00, 1'b0);
        check(64'(processor_id_en_o), 64'h1, "foreign address");
        wr(SMB_DEFAULT_ADDR, CFG1_OFF, 8'h5F, 1'b1);
        check(64'(processor_id_en_o), 64'h0, "default address");
        rd(CFG1_OFF, 8'h5F);
        // pointer outside the table: acked, dropped, reads zero
        wr(SMB_DEV_ADDR, 8'h20, 8'hA5, 1'b1);
        rd(8'h20, 8'h00);
        // diode pair three, six fan inputs, both pins +1.5V
        cfg(32'h3E0E_185C);
        check(64'(pins), 64'({1'h0, 8'hCF, 4'h3, 2'h2, 2'h1, 2'h2, 2'h2, 2'h0, 1'h0, 1'h1, 12'hE8F}),
              "second preset");
        do_reset();
        rd(CFG2_OFF, 8'h00);
        test_done();
    end

endmodule : monitor_pin_function_select_test
